// [rtl/irq_sticky.sv]
/*
 * Sticky event bits with write-one-to-clear and a mask onto one level interrupt.
 * Assumes set and clear are single-cycle pulses on hclk.
 */
`timescale 1ns/100ps

module irq_sticky #(
   parameter int WIDTH = 3
) (
   // Clock and reset
   input  wire logic             hclk,
   input  wire logic             hresetn,
   // Events and software
   input  wire logic [WIDTH-1:0] set_in,
   input  wire logic [WIDTH-1:0] clear_in,
   input  wire logic [WIDTH-1:0] mask_in,
   // Results
   output logic      [WIDTH-1:0] status_reg,
   output logic                  irq
);

   for (genvar i = 0; i < WIDTH; i++) begin : g_bit
      // Set wins over a clear in the same cycle
      always_ff @(posedge hclk or negedge hresetn) begin
         if (!hresetn) begin
            status_reg[i] <= 1'b0;
         end else if (set_in[i]) begin
            status_reg[i] <= 1'b1;
         end else if (clear_in[i]) begin
            status_reg[i] <= 1'b0;
         end
      end
   end

   assign irq = |(status_reg & mask_in);

endmodule : irq_sticky

// [rtl/low_leakage_wakeup_unit.sv]
/*
 * Wake-up unit for the low-leakage stop modes: watches wake pins and module flags,
 * raises one wake request to the power mode controller, registers over AHB-Lite.
 * Assumes the power mode controller drives stop_active and stop_is_retention on hclk
 * and that hclk keeps running while the unit is armed.
 */
// Function
// RULE_01 - Detection runs only once a retention or very-low-leakage stop mode is entered.
// RULE_02 - Leaving the retention stop mode disables the unit at once with no software step.
// RULE_03 - After a very-low-leakage stop the unit keeps detecting until software acknowledges.
// RULE_04 - There are 32 wake pins: 0-15 device pins, 26 USB supply, 27-28 USB data, rest unused.
// RULE_05 - There are 8 module inputs: 0 low-power timer, 1 comparator, 5 RTC alarm, 7 seconds.
// RULE_06 - The two USB data wake pins count only while the chip runs as a USB host.
// RULE_07 - Software enables the source peripheral and its interrupt before using its flag.
// RULE_08 - A per-module enable bit gates each module flag onto the wake path.
// RULE_09 - Module flags are never cleared here; only their own peripheral clears them.
// RULE_10 - An NMI pin enabled at stop entry raises an NMI on exit unless flash disables it.
// RULE_11 - Software keeps this unit's interrupt unmasked in the interrupt controller.
// RULE_12 - Any enabled active source while armed raises one wake request.
`timescale 1ns/100ps
`include "wakeup_cfg.svh"

module low_leakage_wakeup_unit (
   // Clock and reset
   input  wire logic                 hclk,
   input  wire logic                 hresetn,
   // AHB-Lite slave
   input  wire logic                 hsel,
   input  wire logic [31:0]          haddr,
   input  wire logic [1:0]           htrans,
   input  wire logic                 hwrite,
   input  wire logic [2:0]           hsize,
   input  wire logic [31:0]          hwdata,
   input  wire logic                 hready,
   output logic      [31:0]          hrdata,
   output logic                      hreadyout,
   output logic                      hresp,
   // Power mode controller
   input  wire logic                 stop_active,
   input  wire logic                 stop_is_retention,
   output logic                      wake_request,
   // Wake sources
   input  wire wakeup_pkg::pin_vec_t wake_pin_input,
   input  wire wakeup_pkg::mod_vec_t module_wake_flag,
   input  wire logic                 usb_host_mode,
   // Non-maskable interrupt pin
   input  wire logic                 nmi_pin,
   input  wire logic                 nmi_pin_disable,
   output logic                      nmi_request,
   // Interrupt
   output logic                      irq
);
   import wakeup_pkg::*;

   ////////////////////////////////////////////////////////////////////////////////
   // Declarations

   wake_state_t state_reg;
   wake_state_t state_next;

   pin_vec_t    pin_enable_reg;
   pin_vec_t    pin_polarity_reg;
   mod_vec_t    module_wake_enable_reg;
   pin_vec_t    pin_flags_reg;
   logic        nmi_enable_reg;
   irq_vec_t    irq_mask_reg;
   irq_vec_t    irq_status;

   logic        wr_pend_reg;
   logic        rd_pend_reg;
   logic [7:0]  addr_reg;
   logic [31:0] hrdata_reg;
   logic [31:0] rd_mux;
   logic        accept;

   pin_vec_t    pin_sync_level;
   logic        nmi_sync_level;
   pin_vec_t    pin_usable;
   pin_vec_t    pin_active;
   mod_vec_t    module_active;
   logic        detecting;
   logic        armed;
   logic        any_source;

   logic        wake_sent_reg;
   logic        wake_request_reg;
   logic        nmi_armed_reg;
   logic        nmi_seen_reg;
   logic        nmi_request_reg;

   logic        wr_pin_flags;
   logic        wr_control;
   logic        wr_irq_status;
   logic        ack_pulse;
   logic        exit_pulse;
   logic        enter_pulse;
   irq_vec_t    irq_set;
   irq_vec_t    irq_clear;
   logic [31:0] status_word;

   ////////////////////////////////////////////////////////////////////////////////
   // Synchronisers for pin levels

   pin_sync #(
      .WIDTH (`PIN_COUNT)
   ) u_pin_sync (
      .hclk     (hclk),
      .hresetn  (hresetn),
      .async_in (wake_pin_input),
      .sync_out (pin_sync_level)
   );

   pin_sync #(
      .WIDTH (1)
   ) u_nmi_sync (
      .hclk     (hclk),
      .hresetn  (hresetn),
      .async_in (nmi_pin),
      .sync_out (nmi_sync_level)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // AHB-Lite slave: reads take one wait state, writes none

   assign accept    = hsel & htrans[1] & hready;
   assign hreadyout = ~rd_pend_reg;
   assign hresp     = 1'b0;
   assign hrdata    = hrdata_reg;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_reg <= 1'b0;
         rd_pend_reg <= 1'b0;
         addr_reg    <= 8'h00;
      end else begin
         wr_pend_reg <= accept & hwrite;
         rd_pend_reg <= accept & ~hwrite;
         if (accept) begin
            addr_reg <= (haddr[31:8] == 24'h00_0000) ? haddr[7:0] : 8'hFF;
         end
      end
   end

   assign wr_pin_flags  = wr_pend_reg && (addr_reg == `OFS_PIN_FLAGS);
   assign wr_control    = wr_pend_reg && (addr_reg == `OFS_CONTROL);
   assign wr_irq_status = wr_pend_reg && (addr_reg == `OFS_IRQ_STATUS);
   assign ack_pulse     = wr_control && hwdata[`CTL_ACK_BIT];

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pin_enable_reg         <= `RST_PIN_ENABLE;
         pin_polarity_reg       <= `RST_PIN_POLARITY;
         module_wake_enable_reg <= `RST_MOD_ENABLE;
         irq_mask_reg           <= `RST_IRQ_MASK;
         nmi_enable_reg         <= 1'b0;
      end else if (wr_pend_reg) begin
         case (addr_reg)
            `OFS_PIN_ENABLE: begin
               pin_enable_reg <= hwdata & `PIN_VALID_MASK;
            end
            `OFS_PIN_POLARITY: begin
               pin_polarity_reg <= hwdata & `PIN_VALID_MASK;
            end
            `OFS_MOD_ENABLE: begin
               module_wake_enable_reg <= hwdata[`MOD_COUNT-1:0] & `MOD_VALID_MASK;
            end
            `OFS_IRQ_MASK: begin
               irq_mask_reg <= hwdata[`IRQ_COUNT-1:0];
            end
            `OFS_CONTROL: begin
               nmi_enable_reg <= hwdata[`CTL_NMI_EN_BIT];
            end
            default: begin
            end
         endcase
      end
   end

   always_comb begin
      status_word                    = 32'h0000_0000;
      status_word[`STS_ARMED_BIT]    = armed;
      status_word[`STS_HOLD_BIT]     = (state_reg == ST_VLL_HOLD);
      status_word[`STS_NMI_ARM_BIT]  = nmi_armed_reg;
      status_word[`STS_USB_HOST_BIT] = usb_host_mode;
      status_word[`STS_SENT_BIT]     = wake_sent_reg;
      status_word[`STS_STOP_BIT]     = stop_active;
      status_word[`STS_RET_BIT]      = (state_reg == ST_ARMED_RET);
   end

   always_comb begin
      case (addr_reg)
         `OFS_PIN_ENABLE:   rd_mux = pin_enable_reg;
         `OFS_PIN_POLARITY: rd_mux = pin_polarity_reg;
         `OFS_MOD_ENABLE:   rd_mux = {24'h00_0000, module_wake_enable_reg};
         `OFS_PIN_FLAGS:    rd_mux = pin_flags_reg;
         `OFS_MOD_FLAGS:    rd_mux = {24'h00_0000, module_active};
         `OFS_STATUS:       rd_mux = status_word;
         `OFS_CONTROL:      rd_mux = {31'h0000_0000, nmi_enable_reg};
         `OFS_IRQ_STATUS:   rd_mux = {29'h0000_0000, irq_status};
         `OFS_IRQ_MASK:     rd_mux = {29'h0000_0000, irq_mask_reg};
         default:           rd_mux = 32'h0000_0000;
      endcase
   end

   // Read data is sampled in the wait state, after any write just ahead of it
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata_reg <= 32'h0000_0000;
      end else if (rd_pend_reg) begin
         hrdata_reg <= rd_mux;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Mode tracking

   assign armed       = (state_reg == ST_ARMED_RET) || (state_reg == ST_ARMED_VLL);
   assign detecting   = armed || (state_reg == ST_VLL_HOLD);  // RULE_01
   assign enter_pulse = (state_reg == ST_IDLE) && (state_next != ST_IDLE);
   assign exit_pulse  = armed && !stop_active;

   always_comb begin
      state_next = state_reg;
      case (state_reg)
         ST_IDLE: begin
            if (stop_active) begin
               state_next = stop_is_retention ? ST_ARMED_RET : ST_ARMED_VLL;  // RULE_01
            end
         end
         ST_ARMED_RET: begin
            if (!stop_active) begin
               state_next = ST_IDLE;  // RULE_02
            end
         end
         ST_ARMED_VLL: begin
            if (!stop_active) begin
               state_next = ST_VLL_HOLD;  // RULE_03
            end
         end
         ST_VLL_HOLD: begin
            if (ack_pulse) begin
               state_next = ST_IDLE;  // RULE_03
            end
         end
         default: begin
            state_next = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_reg <= ST_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Source qualification

   // USB data lines only in host mode, unused pins never
   assign pin_usable = `PIN_VALID_MASK
                       & ~(usb_host_mode ? 32'h0000_0000 : `PIN_USB_DATA);  // RULE_04 RULE_06

   assign pin_active    = (pin_sync_level ^ pin_polarity_reg) & pin_enable_reg & pin_usable;
   // Flags pass live; the peripheral owns their clearing
   assign module_active = module_wake_flag & module_wake_enable_reg
                          & `MOD_VALID_MASK;  // RULE_05 RULE_08 RULE_09
   assign any_source    = |pin_active || |module_active;

   // Pin flags: set wins over a write-one clear
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pin_flags_reg <= 32'h0000_0000;
      end else begin
         pin_flags_reg <= (pin_flags_reg & ~(wr_pin_flags ? hwdata : 32'h0000_0000))
                          | (detecting ? pin_active : 32'h0000_0000);  // RULE_03
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Wake request: one pulse per stop entry

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wake_sent_reg    <= 1'b0;
         wake_request_reg <= 1'b0;
      end else begin
         wake_request_reg <= armed && any_source && !wake_sent_reg;  // RULE_12
         if (enter_pulse) begin
            wake_sent_reg <= 1'b0;
         end else if (armed && any_source) begin
            wake_sent_reg <= 1'b1;  // RULE_12
         end
      end
   end

   assign wake_request = wake_request_reg;

   ////////////////////////////////////////////////////////////////////////////////
   // NMI pin: enable latched at entry, request on exit

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         nmi_armed_reg   <= 1'b0;
         nmi_seen_reg    <= 1'b0;
         nmi_request_reg <= 1'b0;
      end else begin
         if (enter_pulse) begin
            nmi_armed_reg <= nmi_enable_reg && !nmi_pin_disable;  // RULE_10
         end else if (state_reg == ST_IDLE) begin
            nmi_armed_reg <= 1'b0;
         end
         if (enter_pulse) begin
            nmi_seen_reg <= 1'b0;
         end else if (armed && nmi_armed_reg && nmi_sync_level) begin
            nmi_seen_reg <= 1'b1;
         end
         nmi_request_reg <= exit_pulse && nmi_armed_reg
                            && (nmi_seen_reg || nmi_sync_level);  // RULE_10
      end
   end

   assign nmi_request = nmi_request_reg;

   ////////////////////////////////////////////////////////////////////////////////
   // Interrupt events

   always_comb begin
      irq_set                = '0;
      irq_set[`IRQ_WAKE_BIT] = wake_request_reg;
      irq_set[`IRQ_NMI_BIT]  = nmi_request_reg;
      irq_set[`IRQ_DONE_BIT] = (state_reg != ST_IDLE) && (state_next == ST_IDLE);
   end

   assign irq_clear = wr_irq_status ? hwdata[`IRQ_COUNT-1:0] : '0;

   irq_sticky #(
      .WIDTH (`IRQ_COUNT)
   ) u_irq (
      .hclk       (hclk),
      .hresetn    (hresetn),
      .set_in     (irq_set),
      .clear_in   (irq_clear),
      .mask_in    (irq_mask_reg),
      .status_reg (irq_status),
      .irq        (irq)
   );

   // hsize is accepted but only whole-word transfers are supported
   logic unused_hsize;
   assign unused_hsize = |hsize;

endmodule : low_leakage_wakeup_unit

// [rtl/pin_sync.sv]
/*
 * Two-stage synchroniser for a group of asynchronous levels.
 * Assumes the inputs are quasi-static against hclk.
 */
`timescale 1ns/100ps

module pin_sync #(
   parameter int WIDTH = 32
) (
   // Clock and reset
   input  wire logic             hclk,
   input  wire logic             hresetn,
   // Levels
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] meta_reg;

   for (genvar i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge hclk or negedge hresetn) begin
         if (!hresetn) begin
            meta_reg[i] <= 1'b0;
            sync_out[i] <= 1'b0;
         end else begin
            meta_reg[i] <= async_in[i];
            sync_out[i] <= meta_reg[i];
         end
      end
   end

endmodule : pin_sync

// [rtl/wakeup_cfg.svh]
/*
 * Register map, field positions, reset values and source masks of the wake-up unit.
 * Assumes inclusion by bare name from the package and the unit's top module.
 */
`ifndef WAKEUP_CFG_SVH
`define WAKEUP_CFG_SVH

// Register byte offsets on the AHB-Lite bus
`define OFS_PIN_ENABLE   8'h00
`define OFS_PIN_POLARITY 8'h04
`define OFS_MOD_ENABLE   8'h08
`define OFS_PIN_FLAGS    8'h0C
`define OFS_MOD_FLAGS    8'h10
`define OFS_STATUS       8'h14
`define OFS_CONTROL      8'h18
`define OFS_IRQ_STATUS   8'h1C
`define OFS_IRQ_MASK     8'h20

// Source layout
`define PIN_COUNT        32
`define MOD_COUNT        8
`define PIN_VALID_MASK   32'h1C00_FFFF
`define PIN_USB_DATA     32'h1800_0000
`define MOD_VALID_MASK   8'hA3

// Control fields
`define CTL_NMI_EN_BIT   0
`define CTL_ACK_BIT      1

// Status fields
`define STS_ARMED_BIT    0
`define STS_HOLD_BIT     1
`define STS_NMI_ARM_BIT  2
`define STS_USB_HOST_BIT 3
`define STS_SENT_BIT     4
`define STS_STOP_BIT     5
`define STS_RET_BIT      6

// Interrupt events
`define IRQ_COUNT        3
`define IRQ_WAKE_BIT     0
`define IRQ_NMI_BIT      1
`define IRQ_DONE_BIT     2

// Reset values
`define RST_PIN_ENABLE   32'h0000_0000
`define RST_PIN_POLARITY 32'h0000_0000
`define RST_MOD_ENABLE   8'h00
`define RST_IRQ_MASK     3'h0

`endif

// [rtl/wakeup_pkg.sv]
/*
 * Types shared by the wake-up unit and its bench.
 * Assumes the constants header sits beside it.
 */
package wakeup_pkg;
`include "wakeup_cfg.svh"

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_ARMED_RET,
      ST_ARMED_VLL,
      ST_VLL_HOLD
   } wake_state_t;

   typedef logic [`PIN_COUNT-1:0] pin_vec_t;
   typedef logic [`MOD_COUNT-1:0] mod_vec_t;
   typedef logic [`IRQ_COUNT-1:0] irq_vec_t;

endpackage : wakeup_pkg

// [verification/power_ctrl_model.sv]
/* Power mode controller model: enters a stop mode on request and leaves it after a
   wake request, promptly or slowly, or when the request is withdrawn.
   Assumes the bench drives go, ret_sel and slow just after rising edges. */
`timescale 1ns/100ps

module power_ctrl_model (
   // Clock and reset
   input  wire logic hclk,
   input  wire logic hresetn,
   // Bench control
   input  wire logic go,
   input  wire logic ret_sel,
   input  wire logic slow,
   // Unit link
   input  wire logic wake_request,
   output logic      stop_active,
   output logic      stop_is_retention
);
   logic       pend_reg;
   logic       done_reg;
   logic [2:0] cnt_reg;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         stop_active       <= 1'b0;
         stop_is_retention <= 1'b0;
         pend_reg          <= 1'b0;
         done_reg          <= 1'b0;
         cnt_reg           <= 3'h0;
      end else if (!go) begin
         stop_active <= 1'b0;
         pend_reg    <= 1'b0;
         done_reg    <= 1'b0;
      end else if (pend_reg) begin
         cnt_reg <= cnt_reg - 3'h1;
         if (cnt_reg == 3'h0) begin
            stop_active <= 1'b0;
            pend_reg    <= 1'b0;
            done_reg    <= 1'b1;
         end
      end else if (wake_request && stop_active) begin
         pend_reg <= 1'b1;
         cnt_reg  <= slow ? 3'h5 : 3'h0;
      end else if (!stop_active && !done_reg) begin
         stop_active       <= 1'b1;
         stop_is_retention <= ret_sel;
      end
   end
endmodule : power_ctrl_model

// [verification/tb.sv]
/* Self-checking bench of the wake-up unit over AHB-Lite and the power controller model.
   Assumes the package, header, design, checker and model are compiled first. */
`timescale 1ns/100ps
`include "wakeup_cfg.svh"

module tb;
   import wakeup_pkg::*;

   logic        hclk, hresetn, hsel, hwrite, hready, hresp, irq;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic        stop_active, stop_is_retention, wake_request, host;
   logic        nmi_pin, ndis, nmi_request, go, ret_sel, slow;
   pin_vec_t    pins;
   mod_vec_t    mflag;
   int          errors, total_checks, wakes, nmis;

   low_leakage_wakeup_unit dut (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
      .hreadyout(hready), .hresp(hresp), .stop_active(stop_active),
      .stop_is_retention(stop_is_retention), .wake_request(wake_request),
      .wake_pin_input(pins), .module_wake_flag(mflag), .usb_host_mode(host),
      .nmi_pin(nmi_pin), .nmi_pin_disable(ndis), .nmi_request(nmi_request), .irq(irq));

   power_ctrl_model pmc (
      .hclk(hclk), .hresetn(hresetn), .go(go), .ret_sel(ret_sel), .slow(slow),
      .wake_request(wake_request), .stop_active(stop_active),
      .stop_is_retention(stop_is_retention));

   initial begin
      hclk = 1'b0;
      forever #50 hclk = ~hclk;
   end

   always @(posedge hclk) begin
      if (wake_request === 1'b1) wakes <= wakes + 1;
      if (nmi_request === 1'b1) nmis <= nmis + 1;
   end

   ////////////////////////////////////////
   task automatic final_report();
      $display("checks %0d mismatches %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : final_report

   task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         errors++;
         $display("BAD %s expected %h seen %h", name, exp, got);
      end
   endtask : check

   // Bounded wait: 0 bus ready, 1 stop entered, 2 stop left, 3 new wake
   task automatic wait_on(input int sel, input int w0);
      int n;
      n = 0;
      do begin
         @(posedge hclk);
         n++;
      end while (n < 40 && !(sel == 0 ? hready === 1'b1 :
                             sel == 3 ? wakes != w0 : stop_active === (sel == 1)));
      if (n >= 40) begin
         errors++;
         final_report();
      end
   endtask : wait_on

   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r);
      hsel   <= 1'b1;
      haddr  <= {24'h00_0000, a};
      htrans <= 2'b10;
      hwrite <= w;
      wait_on(0, 0);
      hsel   <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      wait_on(0, 0);
      r = hrdata;
      check("hresp", 32'h0000_0000, 32'(hresp));
   endtask : xfer

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      xfer(1'b1, a, d, r);
   endtask : wr

   task automatic rd(input string name, input logic [7:0] a, input logic [31:0] m,
                     input logic [31:0] exp);
      logic [31:0] r;
      xfer(1'b0, a, 32'h0000_0000, r);
      check(name, exp, r & m);
   endtask : rd

   task automatic chk_irq(input logic exp);
      @(negedge hclk);
      check("irq", {31'h0, exp}, {31'h0, irq});
      @(posedge hclk);
   endtask : chk_irq

   task automatic enter(input logic ret);
      ret_sel <= ret;
      go      <= 1'b1;
      wait_on(1, 0);
   endtask : enter

   ////////////////////////////////////////
   task automatic t_regs();
      rd("pin_en_rst", `OFS_PIN_ENABLE, 32'hFFFF_FFFF, 32'h0000_0000);
      rd("mask_rst", `OFS_IRQ_MASK, 32'hFFFF_FFFF, 32'h0000_0000);
      wr(`OFS_PIN_ENABLE, 32'hFFFF_FFFF);
      rd("pin_valid", `OFS_PIN_ENABLE, 32'hFFFF_FFFF, 32'h1C00_FFFF);
      wr(`OFS_MOD_ENABLE, 32'hFFFF_FFFF);
      rd("mod_valid", `OFS_MOD_ENABLE, 32'hFFFF_FFFF, 32'h0000_00A3);
      rd("unmapped", 8'h40, 32'hFFFF_FFFF, 32'h0000_0000);
      wr(`OFS_PIN_ENABLE, 32'h0800_0000);
      wr(`OFS_MOD_ENABLE, 32'h0000_0002);
      $display("t_regs done");
   endtask : t_regs

   task automatic t_usb_ret();
      int w0;
      w0 = wakes;
      wr(`OFS_IRQ_MASK, 32'h0000_0007);
      pins[27] <= 1'b1;
      slow     <= 1'b1;
      repeat (8) @(posedge hclk);
      rd("idle_flags", `OFS_PIN_FLAGS, 32'hFFFF_FFFF, 32'h0000_0000);
      enter(1'b1);
      repeat (8) @(posedge hclk);
      check("usb_device", 32'(w0), 32'(wakes));
      host <= 1'b1;
      wait_on(3, w0);
      wait_on(2, 0);
      go <= 1'b0;
      repeat (8) @(posedge hclk);
      check("ret_wakes", 32'(w0 + 1), 32'(wakes));
      rd("ret_off", `OFS_STATUS, 32'h0000_0043, 32'h0000_0000);
      rd("usb_flag", `OFS_PIN_FLAGS, 32'hFFFF_FFFF, 32'h0800_0000);
      chk_irq(1'b1);
      wr(`OFS_IRQ_MASK, 32'h0000_0000);
      chk_irq(1'b0);
      wr(`OFS_IRQ_STATUS, 32'h0000_0007);
      rd("irq_clr", `OFS_IRQ_STATUS, 32'h0000_0007, 32'h0000_0000);
      wr(`OFS_PIN_FLAGS, 32'hFFFF_FFFF);
      rd("flag_clr", `OFS_PIN_FLAGS, 32'hFFFF_FFFF, 32'h0000_0000);
      pins[27] <= 1'b0;
      slow     <= 1'b0;
      $display("t_usb_ret done");
   endtask : t_usb_ret

   task automatic t_vll();
      int w0;
      w0 = wakes;
      mflag <= 8'h05;
      enter(1'b0);
      repeat (8) @(posedge hclk);
      check("mod_gate", 32'(w0), 32'(wakes));
      mflag <= 8'h07;
      wait_on(3, w0);
      wait_on(2, 0);
      go <= 1'b0;
      rd("mod_flags", `OFS_MOD_FLAGS, 32'hFFFF_FFFF, 32'h0000_0002);
      rd("hold", `OFS_STATUS, 32'h0000_0003, 32'h0000_0002);
      wr(`OFS_PIN_ENABLE, 32'h0000_0001);
      wr(`OFS_PIN_POLARITY, 32'h0000_0001);
      repeat (8) @(posedge hclk);
      rd("hold_flags", `OFS_PIN_FLAGS, 32'h0000_0001, 32'h0000_0001);
      check("hold_wakes", 32'(w0 + 1), 32'(wakes));
      wr(`OFS_CONTROL, 32'h0000_0002);
      rd("acked", `OFS_STATUS, 32'h0000_0003, 32'h0000_0000);
      mflag   <= 8'h00;
      wr(`OFS_PIN_ENABLE, 32'h0000_0000);
      $display("t_vll done");
   endtask : t_vll

   task automatic t_nmi();
      int n0;
      wr(`OFS_CONTROL, 32'h0000_0001);
      for (int k = 0; k < 2; k++) begin
         n0 = nmis;
         ndis <= k[0];
         enter(1'b0);
         rd("nmi_arm", `OFS_STATUS, 32'h0000_0004, k ? 32'h0 : 32'h4);
         nmi_pin <= 1'b1;
         repeat (6) @(posedge hclk);
         go <= 1'b0;
         wait_on(2, 0);
         repeat (4) @(posedge hclk);
         check("nmi_count", 32'(n0 + 1 - k), 32'(nmis));
         nmi_pin <= 1'b0;
         wr(`OFS_CONTROL, 32'h0000_0003);
      end
      rd("nmi_irq", `OFS_IRQ_STATUS, 32'h0000_0002, 32'h0000_0002);
      $display("t_nmi done");
   endtask : t_nmi

   initial begin
      hresetn = 1'b0;
      hsel    = 1'b0;
      haddr   = 32'h0000_0000;
      htrans  = 2'b00;
      hwrite  = 1'b0;
      hsize   = 3'h2;
      hwdata  = 32'h0000_0000;
      pins    = '0;
      mflag   = 8'h00;
      host    = 1'b0;
      nmi_pin = 1'b0;
      ndis    = 1'b0;
      go      = 1'b0;
      ret_sel = 1'b0;
      slow    = 1'b0;
      errors  = 0;
      total_checks = 0;
      wakes   = 0;
      nmis    = 0;
      repeat (20) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      t_regs();
      t_usb_ret();
      t_vll();
      t_nmi();
      final_report();
   end
endmodule : tb

// [verification/wakeup_monitor.sv]
/* Checker for the wake-up unit: bus answer timing, wake and NMI pulses.
   Assumes it is bound to the unit's top module and sees only its ports. */
`timescale 1ns/100ps

module wakeup_monitor (
   // Clock and reset
   input wire logic       hclk,
   input wire logic       hresetn,
   // Bus
   input wire logic       hsel,
   input wire logic [1:0] htrans,
   input wire logic       hwrite,
   input wire logic       hready,
   input wire logic       hreadyout,
   // Power link
   input wire logic       stop_active,
   input wire logic       stop_is_retention,
   input wire logic       wake_request,
   input wire logic       nmi_request
);
   logic stop_q;
   logic ret_q;

   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);

   // Remembers which stop mode was entered
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         stop_q <= 1'b0;
         ret_q  <= 1'b0;
      end else begin
         stop_q <= stop_active;
         if (stop_active && !stop_q) begin
            ret_q <= stop_is_retention;
         end
      end
   end

   ////////////////////////////////////////
   sequence s_rd_taken;
      hsel && htrans[1] && hready && !hwrite;
   endsequence
   sequence s_wr_taken;
      hsel && htrans[1] && hready && hwrite;
   endsequence
   sequence s_read_wait;
      !hreadyout ##1 hreadyout;
   endsequence

   property p_read_wait;
      s_rd_taken |=> s_read_wait;
   endproperty
   property p_write_ready;
      s_wr_taken |=> hreadyout;
   endproperty
   property p_wake_needs_stop;
      wake_request |-> $past(stop_active, 2);
   endproperty
   property p_wake_single;
      wake_request |=> !wake_request [*4];
   endproperty
   property p_ret_quiet;
      $fell(stop_active) && ret_q |-> ##2 !wake_request [*4];
   endproperty
   property p_hold_quiet;
      $fell(stop_active) && !ret_q |-> ##2 !wake_request [*4];
   endproperty
   property p_nmi_after_exit;
      nmi_request |-> $past(stop_active, 2) && !$past(stop_active);
   endproperty
   property p_nmi_single;
      nmi_request |=> !nmi_request;
   endproperty

   a_read_wait: assert property (p_read_wait) else $error("read wait state wrong");
   a_write_ready: assert property (p_write_ready) else $error("write not ready");
   a_wake_needs_stop: assert property (p_wake_needs_stop) else $error("wake no stop");
   a_wake_single: assert property (p_wake_single) else $error("wake repeated");
   a_ret_quiet: assert property (p_ret_quiet) else $error("wake after retention exit");
   a_hold_quiet: assert property (p_hold_quiet) else $error("wake during hold");
   a_nmi_after_exit: assert property (p_nmi_after_exit) else $error("nmi misplaced");
   a_nmi_single: assert property (p_nmi_single) else $error("nmi repeated");
endmodule : wakeup_monitor

bind low_leakage_wakeup_unit wakeup_monitor mon (
   .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
   .hready(hready), .hreadyout(hreadyout), .stop_active(stop_active),
   .stop_is_retention(stop_is_retention), .wake_request(wake_request),
   .nmi_request(nmi_request)
);
